// ==== logic/gpcd_port.sv ====
// GPIO port with per-pin controls and change detection, behind an AXI4-Lite slave
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
module gpcd_port
  import gpcd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [GPCD_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [GPCD_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port A pads
  input wire logic [GPCD_PA_W-1:0] port_a_in_schmitt,
  input wire logic [GPCD_PA_W-1:0] port_a_in_ttl,
  output logic [GPCD_PA_W-1:0] port_a_out,
  output logic [GPCD_PA_W-1:0] port_a_oe,
  output logic [GPCD_PA_W-1:0] port_a_slew_limit_en,
  output logic [GPCD_PA_W-1:0] port_a_analog_en,
  // Port B inputs
  input wire logic [GPCD_PB_W-1:0] port_b_in,
  output logic irq
);

  // ****************************************
  // Pin input path
  // ****************************************
  logic [GPCD_PA_W-1:0] pa_st_sync;
  logic [GPCD_PA_W-1:0] pa_ttl_sync;
  logic [GPCD_PB_W-1:0] pb_sync;
  logic [GPCD_PA_W-1:0] pa_level;
  logic [GPCD_PA_W-1:0] pa_rise;
  logic [GPCD_PA_W-1:0] pa_fall;
  logic [GPCD_PB_W-1:0] pb_rise;
  logic [GPCD_PB_W-1:0] pb_fall;

  gpcd_sync #(.W(GPCD_PA_W)) u_sync_pa_st (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(port_a_in_schmitt),
    .sync_out(pa_st_sync)
  );

  gpcd_sync #(.W(GPCD_PA_W)) u_sync_pa_ttl (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(port_a_in_ttl),
    .sync_out(pa_ttl_sync)
  );

  gpcd_sync #(.W(GPCD_PB_W)) u_sync_pb (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(port_b_in),
    .sync_out(pb_sync)
  );

  // ****************************************
  // Control registers
  // ****************************************
  logic [5:0] pa_dir_reg, pa_dir_next;
  logic [5:0] pa_lat_reg, pa_lat_next;
  logic [5:0] pa_od_reg, pa_od_next;
  logic [5:0] pa_slew_reg, pa_slew_next;
  logic [5:0] pa_thr_reg, pa_thr_next;
  logic [5:0] pa_ana_reg, pa_ana_next;
  logic [5:0] pa_rise_en_reg, pa_rise_en_next;
  logic [5:0] pa_fall_en_reg, pa_fall_en_next;
  logic [5:0] pa_flag_reg, pa_flag_next;
  logic [7:0] pb_rise_en_reg, pb_rise_en_next;
  logic [7:0] pb_fall_en_reg, pb_fall_en_next;
  logic [7:0] pb_flag_reg, pb_flag_next;
  logic sum_flag_reg, sum_flag_next;
  logic [1:0] irq_stat_reg, irq_stat_next;
  logic [1:0] irq_mask_reg, irq_mask_next;

  // Threshold choice feeds both reads and change detection; analog pins read 0
  assign pa_level = ((pa_thr_reg & pa_st_sync) | (~pa_thr_reg & pa_ttl_sync)) & ~pa_ana_reg; // [R10] [R12]

  gpcd_edge #(.W(GPCD_PA_W)) u_edge_pa (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(pa_level),
    .rise(pa_rise),
    .fall(pa_fall)
  );

  gpcd_edge #(.W(GPCD_PB_W)) u_edge_pb (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(pb_sync),
    .rise(pb_rise),
    .fall(pb_fall)
  );

  // ****************************************
  // AXI4-Lite handshake state
  // ****************************************
  logic aw_full_reg, aw_full_next;
  logic w_full_reg, w_full_next;
  logic [GPCD_AW-1:0] waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] rd_word;
  logic rd_hit;

  // Address decode shared by the read and write paths
  function automatic logic gpcd_mapped(input logic [GPCD_AW-1:0] a);
    unique case (a)
      GPCD_PA_DATA_ADDR, GPCD_PA_DIR_ADDR, GPCD_PA_LAT_ADDR, GPCD_PA_OD_ADDR,
      GPCD_PA_SLEW_ADDR, GPCD_PA_THR_ADDR, GPCD_PA_ANA_ADDR, GPCD_PA_RISE_ADDR,
      GPCD_PA_FALL_ADDR, GPCD_PA_FLAG_ADDR, GPCD_PB_DATA_ADDR, GPCD_PB_RISE_ADDR,
      GPCD_PB_FALL_ADDR, GPCD_PB_FLAG_ADDR, GPCD_SUM_ADDR, GPCD_IRQ_STAT_ADDR,
      GPCD_IRQ_MASK_ADDR: gpcd_mapped = 1'b1;
      default: gpcd_mapped = 1'b0;
    endcase
  endfunction : gpcd_mapped

  // Byte-lane 0 merge of a write into a six-bit field
  function automatic logic [5:0] gpcd_merge6(input logic [5:0] old, input logic [31:0] d, input logic [3:0] s);
    gpcd_merge6 = s[0] ? d[5:0] : old;
  endfunction : gpcd_merge6

  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && !rvalid_reg;

  always_comb begin
    rd_hit = gpcd_mapped(s_axi_araddr);
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      GPCD_PA_DATA_ADDR: rd_word[5:0] = pa_level; // [R5]
      GPCD_PA_DIR_ADDR: rd_word[5:0] = pa_dir_reg;
      GPCD_PA_LAT_ADDR: rd_word[5:0] = pa_lat_reg;
      GPCD_PA_OD_ADDR: rd_word[5:0] = pa_od_reg;
      GPCD_PA_SLEW_ADDR: rd_word[5:0] = pa_slew_reg;
      GPCD_PA_THR_ADDR: rd_word[5:0] = pa_thr_reg;
      GPCD_PA_ANA_ADDR: rd_word[5:0] = pa_ana_reg;
      GPCD_PA_RISE_ADDR: rd_word[5:0] = pa_rise_en_reg;
      GPCD_PA_FALL_ADDR: rd_word[5:0] = pa_fall_en_reg;
      GPCD_PA_FLAG_ADDR: rd_word[5:0] = pa_flag_reg;
      GPCD_PB_DATA_ADDR: rd_word[7:0] = pb_sync;
      GPCD_PB_RISE_ADDR: rd_word[7:0] = pb_rise_en_reg;
      GPCD_PB_FALL_ADDR: rd_word[7:0] = pb_fall_en_reg;
      GPCD_PB_FLAG_ADDR: rd_word[7:0] = pb_flag_reg;
      GPCD_SUM_ADDR: rd_word[0] = sum_flag_reg;
      GPCD_IRQ_STAT_ADDR: rd_word[1:0] = irq_stat_reg;
      GPCD_IRQ_MASK_ADDR: rd_word[1:0] = irq_mask_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Bus channel next state
  // ****************************************
  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_next = 1'b1;
      waddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = gpcd_mapped(waddr_reg) ? GPCD_RESP_OKAY : GPCD_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rdata_next = rd_word;
      rresp_next = rd_hit ? GPCD_RESP_OKAY : GPCD_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= GPCD_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= GPCD_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************
  // Register file next state
  // ****************************************
  always_comb begin
    logic wr_lane0;
    logic [5:0] pa_set;
    logic [7:0] pb_set;
    logic [1:0] irq_set;
    wr_lane0 = wr_fire && wstrb_reg[0];
    pa_set = (pa_rise & pa_rise_en_reg) | (pa_fall & pa_fall_en_reg); // [R15]
    pb_set = (pb_rise & pb_rise_en_reg) | (pb_fall & pb_fall_en_reg); // [R17] [R18]
    irq_set = {|pb_set, |pa_set};
    pa_dir_next = pa_dir_reg;
    pa_lat_next = pa_lat_reg;
    pa_od_next = pa_od_reg;
    pa_slew_next = pa_slew_reg;
    pa_thr_next = pa_thr_reg;
    pa_ana_next = pa_ana_reg;
    pa_rise_en_next = pa_rise_en_reg;
    pa_fall_en_next = pa_fall_en_reg;
    pa_flag_next = pa_flag_reg;
    pb_rise_en_next = pb_rise_en_reg;
    pb_fall_en_next = pb_fall_en_reg;
    pb_flag_next = pb_flag_reg;
    sum_flag_next = sum_flag_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    if (wr_fire) begin
      unique case (waddr_reg)
        // Pins are sampled and the write merged over them before reaching the latch
        GPCD_PA_DATA_ADDR: pa_lat_next = gpcd_merge6(pa_level, wdata_reg, wstrb_reg); // [R5] [R6]
        GPCD_PA_DIR_ADDR: pa_dir_next = gpcd_merge6(pa_dir_reg, wdata_reg, wstrb_reg);
        GPCD_PA_LAT_ADDR: pa_lat_next = gpcd_merge6(pa_lat_reg, wdata_reg, wstrb_reg);
        GPCD_PA_OD_ADDR: pa_od_next = gpcd_merge6(pa_od_reg, wdata_reg, wstrb_reg);
        GPCD_PA_SLEW_ADDR: pa_slew_next = gpcd_merge6(pa_slew_reg, wdata_reg, wstrb_reg);
        GPCD_PA_THR_ADDR: pa_thr_next = gpcd_merge6(pa_thr_reg, wdata_reg, wstrb_reg);
        GPCD_PA_ANA_ADDR: pa_ana_next = gpcd_merge6(pa_ana_reg, wdata_reg, wstrb_reg);
        GPCD_PA_RISE_ADDR: pa_rise_en_next = gpcd_merge6(pa_rise_en_reg, wdata_reg, wstrb_reg);
        GPCD_PA_FALL_ADDR: pa_fall_en_next = gpcd_merge6(pa_fall_en_reg, wdata_reg, wstrb_reg);
        GPCD_PA_FLAG_ADDR: if (wr_lane0) pa_flag_next = pa_flag_reg & wdata_reg[5:0]; // [R16]
        GPCD_PB_RISE_ADDR: if (wr_lane0) pb_rise_en_next = wdata_reg[7:0];
        GPCD_PB_FALL_ADDR: if (wr_lane0) pb_fall_en_next = wdata_reg[7:0];
        GPCD_PB_FLAG_ADDR: if (wr_lane0) pb_flag_next = pb_flag_reg & wdata_reg[7:0]; // [R16]
        GPCD_SUM_ADDR: if (wr_lane0) sum_flag_next = sum_flag_reg & wdata_reg[0]; // [R16]
        GPCD_IRQ_MASK_ADDR: if (wr_lane0) irq_mask_next = wdata_reg[1:0];
        default: pa_lat_next = pa_lat_reg;
      endcase
    end
    // The input-only pin keeps its direction bit at 1
    pa_dir_next[GPCD_INPUT_ONLY_BIT] = 1'b1; // [R4]
    // Hardware sets are applied after software clears so a same-cycle event is kept
    pa_flag_next = pa_flag_next | pa_set; // [R15] [R16]
    pb_flag_next = pb_flag_next | pb_set; // [R17] [R18]
    sum_flag_next = sum_flag_next | (|pb_set); // [R17] [R18]
    if (rd_fire && s_axi_araddr == GPCD_IRQ_STAT_ADDR) begin
      irq_stat_next = 2'h0;
    end
    irq_stat_next = irq_stat_next | irq_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_dir_reg <= GPCD_PA_DIR_RST;
      pa_lat_reg <= GPCD_PA_ZERO_RST;
      pa_od_reg <= GPCD_PA_ZERO_RST;
      pa_slew_reg <= GPCD_PA_ZERO_RST;
      pa_thr_reg <= GPCD_PA_ZERO_RST;
      pa_ana_reg <= GPCD_PA_ANA_RST; // [R14]
      pa_rise_en_reg <= GPCD_PA_ZERO_RST;
      pa_fall_en_reg <= GPCD_PA_ZERO_RST;
      pa_flag_reg <= GPCD_PA_ZERO_RST;
      pb_rise_en_reg <= GPCD_PB_ZERO_RST;
      pb_fall_en_reg <= GPCD_PB_ZERO_RST;
      pb_flag_reg <= GPCD_PB_ZERO_RST;
      sum_flag_reg <= 1'b0;
      irq_stat_reg <= GPCD_IRQ_RST;
      irq_mask_reg <= GPCD_IRQ_RST;
    end else begin
      pa_dir_reg <= pa_dir_next;
      pa_lat_reg <= pa_lat_next;
      pa_od_reg <= pa_od_next;
      pa_slew_reg <= pa_slew_next;
      pa_thr_reg <= pa_thr_next;
      pa_ana_reg <= pa_ana_next;
      pa_rise_en_reg <= pa_rise_en_next;
      pa_fall_en_reg <= pa_fall_en_next;
      pa_flag_reg <= pa_flag_next;
      pb_rise_en_reg <= pb_rise_en_next;
      pb_fall_en_reg <= pb_fall_en_next;
      pb_flag_reg <= pb_flag_next;
      sum_flag_reg <= sum_flag_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // ****************************************
  // Pad drive and outputs
  // ****************************************
  // Direction and open drain gate the driver, analog select plays no part; open drain only sinks a 0
  always_comb begin
    port_a_out = pa_lat_reg; // [R3] [R13]
    port_a_oe = ~pa_dir_reg & (~pa_od_reg | ~pa_lat_reg); // [R1] [R2] [R3] [R7] [R8] [R13]
    port_a_oe[GPCD_INPUT_ONLY_BIT] = 1'b0; // [R4]
  end

  assign port_a_slew_limit_en = pa_slew_reg; // [R9]
  assign port_a_analog_en = pa_ana_reg; // [R12]
  assign irq = |(irq_stat_reg & irq_mask_reg);

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

endmodule : gpcd_port

// ==== logic/gpcd_pkg.sv ====
// Package with the register map, reset values and widths of the GPIO port with change detection
// Function
// R1 - Port A has six bidirectional pins, each steered by its own control bits.
// R2 - Direction bit 1 makes the pin an input and turns its driver off.
// R3 - Direction bit 0 drives the pin from the output latch.
// R4 - The input-only pin is never driven; its direction bit always reads 1.
// R5 - Data reads return pin states; data writes go to the output latch.
// R6 - Data writes sample the pins, merge the write, then store into the latch.
// R7 - Direction bits control the drivers even for analog pins; software keeps them set.
// R8 - Open-drain bit set gives sink-only drive; cleared gives push-pull.
// R9 - Slew bit set limits the driver slew rate; cleared gives fastest slew.
// R10 - Threshold bit picks Schmitt or TTL input for reads and change detection.
// R11 - Software changes thresholds only while peripherals are disabled.
// R12 - Analog select set makes digital reads return 0 and enables analog use.
// R13 - Analog select does not affect digital output drive.
// R14 - After reset all analog select bits are set.
// R15 - Port A flag sets on enabled rising or enabled falling pin edge.
// R16 - Change flags are set by hardware and cleared by software writing 0.
// R17 - Port B enabled rising edge sets its flag and the summary flag.
// R18 - Port B enabled falling edge sets its flag and the summary flag.
// R19 - Edge inputs are synchronised and compared with the last sample, one flag per edge.
package gpcd_pkg;

  localparam int GPCD_PA_W = 6;
  localparam int GPCD_PB_W = 8;
  localparam int GPCD_AW = 8;
  localparam int GPCD_INPUT_ONLY_BIT = 3;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] GPCD_PA_DATA_ADDR = 8'h00;
  localparam logic [7:0] GPCD_PA_DIR_ADDR = 8'h04;
  localparam logic [7:0] GPCD_PA_LAT_ADDR = 8'h08;
  localparam logic [7:0] GPCD_PA_OD_ADDR = 8'h0c;
  localparam logic [7:0] GPCD_PA_SLEW_ADDR = 8'h10;
  localparam logic [7:0] GPCD_PA_THR_ADDR = 8'h14;
  localparam logic [7:0] GPCD_PA_ANA_ADDR = 8'h18;
  localparam logic [7:0] GPCD_PA_RISE_ADDR = 8'h1c;
  localparam logic [7:0] GPCD_PA_FALL_ADDR = 8'h20;
  localparam logic [7:0] GPCD_PA_FLAG_ADDR = 8'h24;
  localparam logic [7:0] GPCD_PB_DATA_ADDR = 8'h28;
  localparam logic [7:0] GPCD_PB_RISE_ADDR = 8'h2c;
  localparam logic [7:0] GPCD_PB_FALL_ADDR = 8'h30;
  localparam logic [7:0] GPCD_PB_FLAG_ADDR = 8'h34;
  localparam logic [7:0] GPCD_SUM_ADDR = 8'h38;
  localparam logic [7:0] GPCD_IRQ_STAT_ADDR = 8'h3c;
  localparam logic [7:0] GPCD_IRQ_MASK_ADDR = 8'h40;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [5:0] GPCD_PA_DIR_RST = 6'h3f;
  localparam logic [5:0] GPCD_PA_ANA_RST = 6'h3f;
  localparam logic [5:0] GPCD_PA_ZERO_RST = 6'h00;
  localparam logic [7:0] GPCD_PB_ZERO_RST = 8'h00;
  localparam logic [1:0] GPCD_IRQ_RST = 2'h0;

  // Interrupt status bit positions
  localparam int GPCD_IRQ_PA_BIT = 0;
  localparam int GPCD_IRQ_PB_BIT = 1;

  localparam logic [1:0] GPCD_RESP_OKAY = 2'h0;
  localparam logic [1:0] GPCD_RESP_SLVERR = 2'h2;

endpackage : gpcd_pkg

// ==== logic/gpcd_sync.sv ====
// Two-stage synchroniser for a group of pin inputs
module gpcd_sync
  import gpcd_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule : gpcd_sync

// ==== logic/gpcd_edge.sv ====
// Rising and falling edge detector on synchronised levels
module gpcd_edge
  import gpcd_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] prev_reg;
  logic [W-1:0] prev_next;
  logic [2:0] primed_reg;
  logic [2:0] primed_next;

  always_comb begin
    prev_next = level;
    primed_next = {primed_reg[1:0], 1'b1};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= '0;
      primed_reg <= 3'h0;
    end else begin
      prev_reg <= prev_next;
      primed_reg <= primed_next;
    end
  end

  // Compare only once the synchroniser has passed real pin samples, so reset sees no edge
  assign rise = primed_reg[2] ? (level & ~prev_reg) : '0; // [R19]
  assign fall = primed_reg[2] ? (~level & prev_reg) : '0; // [R19]

endmodule : gpcd_edge

// ==== tb/gpcd_pads.sv ====
// Model of the pads and the circuit attached to port A
module gpcd_pads
  import gpcd_pkg::*;
(
  input wire logic [GPCD_PA_W-1:0] port_a_out,
  input wire logic [GPCD_PA_W-1:0] port_a_oe,
  input wire logic [GPCD_PA_W-1:0] ext_val,
  input wire logic [GPCD_PA_W-1:0] ext_en,
  input wire logic [GPCD_PA_W-1:0] ext_mid,
  output logic [GPCD_PA_W-1:0] port_a_in_schmitt,
  output logic [GPCD_PA_W-1:0] port_a_in_ttl
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [GPCD_PA_W-1:0] level;
  // Pad driver first, then the outside driver, else the pull-up
  assign level = (port_a_oe & port_a_out) | (~port_a_oe & ext_en & ext_val) | (~port_a_oe & ~ext_en);
  // A level between the thresholds reads low on Schmitt and high on TTL
  assign port_a_in_schmitt = level & ~ext_mid;
  assign port_a_in_ttl = level | ext_mid;
endmodule : gpcd_pads

// ==== tb/gpcd_port_checker.sv ====
// Concurrent checks on the ports of the GPIO port block
module gpcd_port_checker
  import gpcd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [GPCD_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [GPCD_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [GPCD_PA_W-1:0] port_a_oe,
  input wire logic [GPCD_PA_W-1:0] port_a_analog_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_input_only_oe: assert property (!port_a_oe[GPCD_INPUT_ONLY_BIT])
    else $error("input-only pin driven");
  a_reset_state: assert property ($rose(aresetn) |-> port_a_analog_en == 6'h3f && port_a_oe == 6'h00)
    else $error("pad state wrong after reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_read_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not retired");
  a_write_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not retired");
  a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h44
    |=> s_axi_rresp == GPCD_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered wrongly");
  a_wr_unmapped: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr >= 8'h44 |-> ##2 s_axi_bvalid && s_axi_bresp == GPCD_RESP_SLVERR)
    else $error("unmapped write answered wrongly");
endmodule : gpcd_port_checker

bind gpcd_port gpcd_port_checker gpcd_port_checker_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a_oe,
  .port_a_analog_en);

// ==== tb/gpcd_port_test.sv ====
// Self-checking testbench of the GPIO port with change detection
module gpcd_port_test
  import gpcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end

  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, port_b_in;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [5:0] port_a_in_schmitt, port_a_in_ttl, port_a_out, port_a_oe, port_a_slew_limit_en, port_a_analog_en;
  logic [5:0] ext_val, ext_en, ext_mid;
  int fails, cmp_count;

  gpcd_port gpcd_port_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_a_in_schmitt, .port_a_in_ttl, .port_a_out, .port_a_oe, .port_a_slew_limit_en, .port_a_analog_en,
    .port_b_in, .irq);
  gpcd_pads gpcd_pads_inst (.port_a_out, .port_a_oe, .ext_val, .ext_en, .ext_mid, .port_a_in_schmitt,
    .port_a_in_ttl);

  always #12.5 aclk = ~aclk;

  // ********************
  // Bus tasks
  // ********************
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic a_ok;
    logic w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge aclk);
      a_ok |= s_axi_awready;
      w_ok |= s_axi_wready;
      s_axi_awvalid <= !a_ok;
      s_axi_wvalid <= !w_ok;
    end
    // Ready is raised only after two idle cycles, so the answer is held waiting for it
    idle(2);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    idle(2);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK($sformatf("reg %h", a), e, rdat)
  endtask : rc

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    rc(8'h04, 32'h3f);
    rc(8'h18, 32'h3f);
    rc(8'h00, 32'h00);
    rc(8'h2c, 32'h00);
    rc(8'h30, 32'h00);
    rc(8'h24, 32'h00);
    `CHK("oe", 6'h00, port_a_oe)
  endtask : t_reset

  task automatic t_drive();
    wr(8'h18, 32'h0, 4'h1);
    rc(8'h00, 32'h3f);
    wr(8'h04, 32'h0, 4'h1);
    rc(8'h04, 32'h08);
    wr(8'h08, 32'h2a, 4'h1);
    `CHK("oe", 6'h37, port_a_oe)
    `CHK("out", 6'h2a, port_a_out)
    rc(8'h00, 32'h2a);
    wr(8'h0c, 32'h3f, 4'h1);
    `CHK("oe", 6'h15, port_a_oe)
    rc(8'h00, 32'h2a);
    wr(8'h10, 32'h05, 4'h1);
    `CHK("slew", 6'h05, port_a_slew_limit_en)
    wr(8'h18, 32'h3f, 4'h1);
    `CHK("oe", 6'h15, port_a_oe)
    `CHK("ana", 6'h3f, port_a_analog_en)
    rc(8'h00, 32'h00);
    wr(8'h18, 32'h0, 4'h1);
    wr(8'h0c, 32'h0, 4'h1);
    wr(8'h04, 32'h3f, 4'h1);
    `CHK("oe", 6'h00, port_a_oe)
  endtask : t_drive

  task automatic t_rmw();
    ext_en <= 6'h3f;
    ext_val <= 6'h15;
    idle(4);
    wr(8'h00, 32'h0, 4'h0);
    rc(8'h08, 32'h15);
    wr(8'h00, 32'h0c, 4'h1);
    rc(8'h08, 32'h0c);
    rc(8'h00, 32'h15);
  endtask : t_rmw

  task automatic t_thresh();
    ext_mid <= 6'h02;
    idle(4);
    rc(8'h00, 32'h17);
    wr(8'h14, 32'h3f, 4'h1);
    rc(8'h00, 32'h15);
    wr(8'h14, 32'h0, 4'h1);
    ext_mid <= 6'h00;
  endtask : t_thresh

  task automatic t_pa_change();
    ext_val <= 6'h00;
    wr(8'h1c, 32'h01, 4'h1);
    wr(8'h20, 32'h04, 4'h1);
    wr(8'h40, 32'h01, 4'h1);
    ext_val <= 6'h05;
    idle(4);
    rc(8'h24, 32'h01);
    `CHK("irq", 1'b1, irq)
    ext_val <= 6'h01;
    idle(4);
    rc(8'h24, 32'h05);
    rc(8'h3c, 32'h01);
    rc(8'h3c, 32'h00);
    `CHK("irq", 1'b0, irq)
    wr(8'h24, 32'h04, 4'h1);
    rc(8'h24, 32'h04);
    ext_val <= 6'h00;
    idle(4);
    rc(8'h24, 32'h04);
  endtask : t_pa_change

  task automatic t_pb_change();
    wr(8'h2c, 32'h80, 4'h1);
    wr(8'h30, 32'h01, 4'h1);
    wr(8'h40, 32'h00, 4'h1);
    port_b_in <= 8'h81;
    idle(4);
    rc(8'h34, 32'h80);
    rc(8'h38, 32'h01);
    `CHK("irq", 1'b0, irq)
    wr(8'h40, 32'h02, 4'h1);
    `CHK("irq", 1'b1, irq)
    rc(8'h3c, 32'h02);
    wr(8'h34, 32'h0, 4'h1);
    wr(8'h38, 32'h0, 4'h1);
    idle(4);
    rc(8'h34, 32'h00);
    port_b_in <= 8'h80;
    idle(4);
    rc(8'h34, 32'h01);
    rc(8'h38, 32'h01);
    rc(8'h28, 32'h80);
    port_b_in <= 8'h00;
    idle(4);
    rc(8'h34, 32'h01);
  endtask : t_pb_change

  task automatic t_unmapped();
    rd(8'h44);
    `CHK("rresp", GPCD_RESP_SLVERR, resp)
    `CHK("rdata", 32'h0, rdat)
    wr(8'h44, 32'hff, 4'h1);
    `CHK("bresp", GPCD_RESP_SLVERR, resp)
  endtask : t_unmapped

  task automatic results();
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, port_b_in, s_axi_wdata, s_axi_wstrb} = '0;
    {ext_val, ext_en, ext_mid} = '0;
    fails = 0;
    cmp_count = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_drive();
    t_rmw();
    t_thresh();
    t_pa_change();
    t_pb_change();
    t_unmapped();
    results();
  end

  initial begin
    #100000;
    fails++;
    results();
  end
endmodule : gpcd_port_test
